// File: rtl/pmi_pkg.sv
/*
 * pmi_pkg: constants, field layouts and state types for the event and
 * interrupt logic of a two-buck, two-linear-regulator power manager.
 * Assumes a 50 MHz core clock; rails are numbered buck0, buck1,
 * linreg0, linreg1 in every 4-bit rail vector.
 */
package pmi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ILIM_TIME_NS = 20000;   // 20 us of peak current regulation
    localparam int SHORT_TIME_NS = 1000000; // 1 ms short/overload debounce
    // least times round up to whole cycles
    localparam int ILIM_CYC = (ILIM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_CYC = (SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ILIM_CW = 10;
    localparam int SHORT_CW = 17;
    localparam logic [1:0] BOOT_DONE = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [3:0] OFS_FLAG = 4'h0;
    localparam logic [3:0] OFS_MASK = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hc;

    // flag register fields
    localparam int F_OC = 0;   // 4 overcurrent flags
    localparam int F_SC = 4;   // 4 short-circuit flags
    localparam int F_HW = 8;
    localparam int F_HSD = 9;
    localparam int F_OV = 10;
    localparam int F_PG = 11;  // 4 goodness flags
    localparam int F_VPD = 15;
    localparam int F_CLK = 16;
    localparam int F_MEAS = 17;
    localparam int F_RST = 18;
    localparam int FLAG_W = 19;
    localparam int F_BGRP = 19; // read-only buck group summary
    localparam int F_LGRP = 20; // read-only linreg group summary

    // mask register fields, 1 = masked
    localparam int M_OC = 0;
    localparam int M_HW = 4;
    localparam int M_PGR = 5;
    localparam int M_PGF = 9;
    localparam int M_VPD = 13;
    localparam int M_CLK = 14;
    localparam int M_MEAS = 15;
    localparam int MASK_W = 16;
    localparam int M_RSTM = 16; // read-only reset mask from otp

    // status register fields
    localparam int S_OC = 0;
    localparam int S_HW = 4;
    localparam int S_HSD = 5;
    localparam int S_OV = 6;
    localparam int S_PG = 7;
    localparam int S_VP = 11;
    localparam int S_CLK = 12;

    // control register fields
    localparam int C_SWRST = 0;
    localparam int C_POL = 1;
    localparam int C_CLKDET = 2;
    localparam int C_EN = 3;   // 4 regulator enables
    localparam int C_GPA = 7;
    localparam int C_GPB = 8;
    localparam int CTRL_W = 9;

    ////////////////////////////////////////////////////////////////////////
    // analog comparator and strap inputs
    typedef struct packed {
        logic [1:0] buck_ilim;
        logic [1:0] linreg_ilim;
        logic [3:0] rail_low;
        logic hot_warn;
        logic hot_sd;
        logic supply_ov;
        logic [3:0] rail_good;
        logic sync_clk;
        logic meas_done;
        logic supply_lockout;
        logic otp_reset_mask;
    } pmi_sense_s;

    // complete block state
    typedef struct packed {
        pmi_sense_s sync1;
        pmi_sense_s sync2;
        pmi_sense_s prev;
        logic [FLAG_W-1:0] flags;
        logic [MASK_W-1:0] mask;
        logic rst_mask;
        logic [CTRL_W-1:0] ctrl;
        logic [1:0][ILIM_CW-1:0] ilim_cnt;
        logic [3:0][SHORT_CW-1:0] short_cnt;
        logic [1:0] boot_cnt;
        logic valid;
        logic pin;
        logic irq_n;
        logic ack;
        logic [31:0] rdata;
    } pmi_state_s;

    localparam pmi_state_s ST_RST = '{valid: 1'b1, pin: 1'b1, irq_n: 1'b1,
        default: '0};

endpackage

// File: rtl/pmi_event_irq.sv
/*
 * pmi_event_irq: event flags, masks, live status, protective shutdown,
 * reset sequencing and the active-low interrupt of a power manager.
 * Assumes comparator levels arrive asynchronously on sense_in, that an
 * Avalon-MM master drives the register port on core_clk, and that the
 * analog rails obey reg_en.
 */
`timescale 1ns/1ps

module pmi_event_irq #(
    parameter int SHORT_CYC = pmi_pkg::SHORT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire pmi_pkg::pmi_sense_s sense_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [3:0] reg_en,
    output logic general_output_a,
    output logic general_output_b,
    output logic power_valid_pin,
    output logic irq_out_n
);

    pmi_pkg::pmi_state_s st_reg;
    pmi_pkg::pmi_state_s st_next;
    logic req;
    logic wr_fire;
    logic [31:0] wd;
    logic [pmi_pkg::FLAG_W-1:0] clr;
    logic [pmi_pkg::FLAG_W-1:0] set;
    logic [3:0] short_hit;
    logic buck_group;
    logic linreg_group;
    logic v;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, answer on the second edge
    // the answer also waits for ce, or a frozen edge would drop the write
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~(st_reg.ack & ce);
    assign wr_fire = avs_write & st_reg.ack;
    assign wd = avs_writedata & {{8{avs_byteenable[3]}},
        {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
        {8{avs_byteenable[0]}}};
    assign avs_readdata = st_reg.rdata;

    // group summaries
    // or of members
    assign buck_group = |{st_reg.flags[pmi_pkg::F_OC +: 2],
        st_reg.flags[pmi_pkg::F_SC +: 2], st_reg.flags[pmi_pkg::F_PG +: 2]};
    assign linreg_group = |{st_reg.flags[pmi_pkg::F_OC+2 +: 2],
        st_reg.flags[pmi_pkg::F_SC+2 +: 2], st_reg.flags[pmi_pkg::F_PG+2 +: 2]};

    // outputs straight from state
    assign reg_en = st_reg.ctrl[pmi_pkg::C_EN +: 4];
    assign general_output_a = st_reg.ctrl[pmi_pkg::C_GPA];
    assign general_output_b = st_reg.ctrl[pmi_pkg::C_GPB];
    assign power_valid_pin = st_reg.pin;
    assign irq_out_n = st_reg.irq_n;

    ////////////////////////////////////////////////////////////////////////
    // read multiplexer, reserved bits and unmapped offsets read zero
    always_comb begin
        rd = 32'h0;
        case (avs_address)
            pmi_pkg::OFS_FLAG: begin
                rd[pmi_pkg::FLAG_W-1:0] = st_reg.flags;
                rd[pmi_pkg::F_BGRP] = buck_group;
                rd[pmi_pkg::F_LGRP] = linreg_group;
            end
            pmi_pkg::OFS_MASK: begin
                rd[pmi_pkg::MASK_W-1:0] = st_reg.mask;
                rd[pmi_pkg::M_RSTM] = st_reg.rst_mask;
            end
            pmi_pkg::OFS_STATUS: begin
                rd[pmi_pkg::S_OC +: 2] = st_reg.sync2.buck_ilim;
                rd[pmi_pkg::S_OC+2 +: 2] = st_reg.sync2.linreg_ilim;
                rd[pmi_pkg::S_HW] = st_reg.sync2.hot_warn;
                rd[pmi_pkg::S_HSD] = st_reg.sync2.hot_sd;
                rd[pmi_pkg::S_OV] = st_reg.sync2.supply_ov;
                rd[pmi_pkg::S_PG +: 4] = st_reg.sync2.rail_good;
                rd[pmi_pkg::S_VP] = st_reg.valid;
                rd[pmi_pkg::S_CLK] = st_reg.sync2.sync_clk;
            end
            pmi_pkg::OFS_CTRL: begin
                rd[pmi_pkg::CTRL_W-1:0] = st_reg.ctrl;
                rd[pmi_pkg::C_SWRST] = 1'b0;
            end
            default: rd = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: set beats clear, so a flag stays while its level cause stays
    always_comb begin
        st_next = st_reg;
        set = '0;
        short_hit = '0;
        clr = '0;
        v = 1'b1;
        // two-flop synchronisers, third stage for edge detection
        st_next.sync1 = sense_in;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        st_next.ack = req & ~st_reg.ack;
        if (req & ~st_reg.ack) begin
            st_next.rdata = rd;
        end
        if (wr_fire && avs_address == pmi_pkg::OFS_FLAG) begin
            clr = wd[pmi_pkg::FLAG_W-1:0];
        end
        if (wr_fire && avs_address == pmi_pkg::OFS_MASK) begin
            st_next.mask = wd[pmi_pkg::MASK_W-1:0];
        end
        if (wr_fire && avs_address == pmi_pkg::OFS_CTRL) begin
            st_next.ctrl = wd[pmi_pkg::CTRL_W-1:0];
            st_next.ctrl[pmi_pkg::C_SWRST] = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (st_reg.sync2.buck_ilim[i]) begin
                if (st_reg.ilim_cnt[i] != pmi_pkg::ILIM_CW'(pmi_pkg::ILIM_CYC - 1)) begin
                    st_next.ilim_cnt[i] = st_reg.ilim_cnt[i] + 1'b1;
                end
            end else begin
                st_next.ilim_cnt[i] = '0;
            end
            set[pmi_pkg::F_OC+i] = ~st_reg.mask[pmi_pkg::M_OC+i] &
                (st_reg.ilim_cnt[i] == pmi_pkg::ILIM_CW'(pmi_pkg::ILIM_CYC - 1));
            set[pmi_pkg::F_OC+2+i] = st_reg.sync2.linreg_ilim[i] &
                ~st_reg.mask[pmi_pkg::M_OC+2+i];
        end
        for (int i = 0; i < 4; i++) begin
            // low output debounce from enable onward
            if (st_reg.ctrl[pmi_pkg::C_EN+i] & st_reg.sync2.rail_low[i]) begin
                st_next.short_cnt[i] = st_reg.short_cnt[i] + 1'b1;
                if (st_reg.short_cnt[i] == pmi_pkg::SHORT_CW'(SHORT_CYC - 1)) begin
                    short_hit[i] = 1'b1;
                    st_next.short_cnt[i] = '0;
                end
            end else begin
                st_next.short_cnt[i] = '0;
            end
            set[pmi_pkg::F_SC+i] = short_hit[i];
            set[pmi_pkg::F_PG+i] = (st_reg.sync2.rail_good[i] &
                ~st_reg.prev.rail_good[i] & ~st_reg.mask[pmi_pkg::M_PGR+i]) |
                (~st_reg.sync2.rail_good[i] & st_reg.prev.rail_good[i] &
                ~st_reg.mask[pmi_pkg::M_PGF+i]);
            // disabled rails do not spoil validity
            if (st_reg.ctrl[pmi_pkg::C_EN+i] & ~st_reg.sync2.rail_good[i]) begin
                v = 1'b0;
            end
        end
        set[pmi_pkg::F_HW] = st_reg.sync2.hot_warn & ~st_reg.mask[pmi_pkg::M_HW];
        set[pmi_pkg::F_HSD] = st_reg.sync2.hot_sd;
        set[pmi_pkg::F_OV] = st_reg.sync2.supply_ov;
        if (st_reg.flags[pmi_pkg::F_HSD] | st_reg.flags[pmi_pkg::F_OV]) begin
            v = 1'b0;
        end
        set[pmi_pkg::F_VPD] = st_reg.valid & ~v & ~st_reg.mask[pmi_pkg::M_VPD];
        st_next.valid = v;
        st_next.pin = v ^ st_next.ctrl[pmi_pkg::C_POL];
        // presence change, detector enabled or not
        set[pmi_pkg::F_CLK] = ~st_reg.mask[pmi_pkg::M_CLK] &
            (st_reg.sync2.sync_clk ^ st_reg.prev.sync_clk);
        if (~st_reg.ctrl[pmi_pkg::C_CLKDET] & st_next.ctrl[pmi_pkg::C_CLKDET] &
            ~st_reg.sync2.sync_clk & ~st_reg.mask[pmi_pkg::M_CLK]) begin
            set[pmi_pkg::F_CLK] = 1'b1;
        end
        set[pmi_pkg::F_MEAS] = st_reg.sync2.meas_done &
            ~st_reg.prev.meas_done & ~st_reg.mask[pmi_pkg::M_MEAS];
        // boot sequence end: otp mask loaded, reset flag raised unless the otp mask is set
        if (st_reg.boot_cnt != pmi_pkg::BOOT_DONE) begin
            st_next.boot_cnt = st_reg.boot_cnt + 1'b1;
            st_next.ctrl[pmi_pkg::C_EN +: 4] = 4'h0;
            if (st_reg.boot_cnt == pmi_pkg::BOOT_DONE - 2'h1) begin
                st_next.rst_mask = st_reg.sync2.otp_reset_mask;
                set[pmi_pkg::F_RST] = ~st_reg.sync2.otp_reset_mask;
            end
        end
        st_next.flags = (st_reg.flags & ~clr) | set;
        // shorted rails switch off
        st_next.ctrl[pmi_pkg::C_EN +: 4] = st_next.ctrl[pmi_pkg::C_EN +: 4] &
            ~short_hit;
        // fault keeps everything off until cleared
        if (st_next.flags[pmi_pkg::F_HSD] | st_next.flags[pmi_pkg::F_OV]) begin
            st_next.ctrl[pmi_pkg::C_EN +: 4] = 4'h0;
            st_next.ctrl[pmi_pkg::C_GPA] = 1'b0;
            st_next.ctrl[pmi_pkg::C_GPB] = 1'b0;
        end
        // pending flags hold the line low
        st_next.irq_n = ~|st_next.flags;
        // lockout or software reset restarts everything but the synchronisers
        if (st_reg.sync2.supply_lockout |
            (wr_fire && avs_address == pmi_pkg::OFS_CTRL &&
            wd[pmi_pkg::C_SWRST])) begin
            st_next = pmi_pkg::ST_RST;
            st_next.sync1 = sense_in;
            st_next.sync2 = st_reg.sync1;
            st_next.prev = st_reg.sync2;
        end
        // clock enable low freezes all state
        if (!ce) begin
            st_next = st_reg;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= pmi_pkg::ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_ilim_wait_time: assert property (
        $rose(st_reg.flags[pmi_pkg::F_OC]) |->
        $past(st_reg.ilim_cnt[0]) == pmi_pkg::ILIM_CW'(pmi_pkg::ILIM_CYC - 1))
        else $error("buck overcurrent flag without full limiting time");
    a_ilim_clear_held: assert property (
        ce && st_reg.flags[pmi_pkg::F_OC+1] && st_reg.sync2.buck_ilim[1] &&
        st_reg.ilim_cnt[1] == pmi_pkg::ILIM_CW'(pmi_pkg::ILIM_CYC - 1) &&
        !(wr_fire && avs_address == pmi_pkg::OFS_CTRL) &&
        !st_reg.sync2.supply_lockout |=> st_reg.flags[pmi_pkg::F_OC+1])
        else $error("buck overcurrent flag cleared while limiting");
    a_linreg_clear_held: assert property (
        ce && st_reg.sync2.linreg_ilim[0] && !st_reg.mask[pmi_pkg::M_OC+2] &&
        !st_reg.sync2.supply_lockout && st_reg.boot_cnt == pmi_pkg::BOOT_DONE
        && !(wr_fire && avs_address == pmi_pkg::OFS_CTRL)
        |=> st_reg.flags[pmi_pkg::F_OC+2])
        else $error("linreg overcurrent flag missing while limiting");
    a_short_disable: assert property (
        $rose(st_reg.flags[pmi_pkg::F_SC]) |-> !reg_en[0])
        else $error("shorted buck left enabled");
    a_short_linreg: assert property (
        $rose(st_reg.flags[pmi_pkg::F_SC+3]) |-> !reg_en[3] &&
        $past(st_reg.sync2.rail_low[3]))
        else $error("linreg short without low output or still enabled");
    a_fault_kills_all: assert property (
        (st_reg.flags[pmi_pkg::F_HSD] || st_reg.flags[pmi_pkg::F_OV]) |->
        reg_en == 4'h0 && !general_output_a && !general_output_b)
        else $error("rail or output on during fault");
    a_ov_sticky: assert property (
        ce && st_reg.sync2.supply_ov && !st_reg.sync2.supply_lockout &&
        !(wr_fire && avs_address == pmi_pkg::OFS_CTRL) |=>
        st_reg.flags[pmi_pkg::F_OV])
        else $error("overvoltage flag not held");
    a_irq_pending: assert property (
        (|st_reg.flags) |-> !irq_out_n)
        else $error("interrupt not asserted with pending flag");
    a_irq_release: assert property (
        $rose(irq_out_n) |-> st_reg.flags == '0)
        else $error("interrupt released with pending flag");
    a_reset_mask: assert property (
        $rose(st_reg.flags[pmi_pkg::F_RST]) |-> !st_reg.rst_mask)
        else $error("reset flag raised while otp mask set");
    a_pin_polarity: assert property (
        ce && !st_reg.sync2.supply_lockout |=>
        power_valid_pin == (st_reg.valid ^ st_reg.ctrl[pmi_pkg::C_POL]))
        else $error("valid pin does not follow polarity");
    a_drop_cause: assert property (
        $rose(st_reg.flags[pmi_pkg::F_VPD]) |-> $past(st_reg.valid) &&
        !st_reg.valid)
        else $error("drop flag without valid falling");
    a_bus_one_wait: assert property (
        (req && avs_waitrequest && ce) |=> !avs_waitrequest || !ce)
        else $error("bus answer not after one wait cycle");

    // event sources that the checks above do not reach, and rails held off during start-up
    a_clk_detect_start: assert property (
        ce && wr_fire && avs_address == pmi_pkg::OFS_CTRL &&
        !wd[pmi_pkg::C_SWRST] && wd[pmi_pkg::C_CLKDET] &&
        !st_reg.ctrl[pmi_pkg::C_CLKDET] && !st_reg.sync2.sync_clk &&
        !st_reg.mask[pmi_pkg::M_CLK] && !st_reg.sync2.supply_lockout |=>
        st_reg.flags[pmi_pkg::F_CLK])
        else $error("detector started without clock but no flag");
    a_meas_edge: assert property (
        $rose(st_reg.flags[pmi_pkg::F_MEAS]) |->
        $past(st_reg.sync2.meas_done) && !$past(st_reg.mask[pmi_pkg::M_MEAS]))
        else $error("measurement flag without completion");
    a_warn_masked: assert property (
        ce && st_reg.mask[pmi_pkg::M_HW] && !st_reg.flags[pmi_pkg::F_HW] |=>
        !st_reg.flags[pmi_pkg::F_HW])
        else $error("masked hot warning raised its flag");
    a_boot_rails_off: assert property (
        st_reg.boot_cnt != pmi_pkg::BOOT_DONE |-> reg_en == 4'h0)
        else $error("rail enabled before start-up finished");

    c_buck_short: cover property ($rose(st_reg.flags[pmi_pkg::F_SC]));
    c_goodness_flag: cover property ($rose(st_reg.flags[pmi_pkg::F_PG]));
    c_hot_shutdown: cover property ($rose(st_reg.flags[pmi_pkg::F_HSD]));
    c_reset_flag: cover property ($rose(st_reg.flags[pmi_pkg::F_RST]));
    c_read_done: cover property (avs_read && !avs_waitrequest);

endmodule

// File: verification/pmi_host_model.sv
/*
 * pmi_host_model: avalon-mm master standing in for the host processor.
 * Assumes the bench calls its tasks from one process, one at a time.
 */
`timescale 1ns/1ps

module pmi_host_model (
    input wire logic core_clk,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    ////////////////////////////////////////////////////////////////////////
    // bus idle from time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end

    // one transfer, held until the rising edge that sees waitrequest low;
    // data is taken and the request dropped at that same edge
    task automatic xfer(input logic wr, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a; // stale address must not look valid
        avs_writedata <= ~d;
    endtask

    task automatic clear(input logic [31:0] w, output logic [31:0] st);
        logic [31:0] q;
        xfer(1'b0, pmi_pkg::OFS_STATUS, 32'h0, st);
        xfer(1'b1, pmi_pkg::OFS_FLAG, w, q);
    endtask
endmodule

// File: verification/tb_top.sv
/*
 * tb_top: self-checking bench for pmi_event_irq driven by a host model.
 * Assumes a 50 MHz clock and the short debounce cut to 20 cycles.
 */
`timescale 1ns/1ps

module tb_top;
    localparam logic [3:0] FL = pmi_pkg::OFS_FLAG;
    localparam logic [3:0] MK = pmi_pkg::OFS_MASK;
    localparam logic [3:0] ST = pmi_pkg::OFS_STATUS;
    localparam logic [3:0] CT = pmi_pkg::OFS_CTRL;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [18:0] sense = '0;
    logic [3:0] addr, be, reg_en;
    logic [31:0] wdata, rdata, q, m;
    logic rd, wr_s, wait_s, gpa, gpb, pin, irq_n, pol;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h2fd9;
    // event table: sense bit, flag bit, mask bit, status bit
    int src[6] = '{15, 10, 9, 8, 3, 2};
    int fb[6] = '{2, 8, 9, 10, 16, 17};
    int mb[6] = '{2, 4, -1, -1, 14, 15};
    int sb[6] = '{2, 4, 5, 6, 12, -1};

    ////////////////////////////////////////////////////////////////////////
    always #10 core_clk = ~core_clk;

    pmi_host_model host (.core_clk(core_clk), .avs_address(addr),
        .avs_read(rd), .avs_write(wr_s), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_s));

    pmi_event_irq #(.SHORT_CYC(20)) dut (.core_clk(core_clk), .nrst(nrst),
        .ce(1'b1), .sense_in(pmi_pkg::pmi_sense_s'(sense)),
        .avs_address(addr), .avs_read(rd), .avs_write(wr_s),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_s), .reg_en(reg_en),
        .general_output_a(gpa), .general_output_b(gpb),
        .power_valid_pin(pin), .irq_out_n(irq_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the nearly two thousand cycles the run needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_errors++;
            $display("mismatch at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask

    // register compare; flag reads also expect the group summary bits
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] x;
        x = e;
        if (a == FL) begin
            x[19] = |(e & 32'h1833);
            x[20] = |(e & 32'h60cc);
        end
        host.xfer(1'b0, a, 32'h0, q);
        n_compared++;
        if (q !== x) begin
            n_errors++;
            $display("mismatch at %0t: reg %h got %h exp %h", $time, a, q, x);
        end
    endtask

    // pin compare {irq, valid pin, gpo a, gpo b, enables}, mid-cycle
    task automatic chk_pin(input logic [7:0] c, input logic [7:0] e);
        @(negedge core_clk);
        n_compared++;
        if (({irq_n, pin, gpa, gpb, reg_en} & c) !== e) begin
            n_errors++;
            $display("mismatch at %0t: pins exp %h", $time, e);
        end
        @(posedge core_clk);
    endtask

    // raise a cause, check flag, status and outputs, clear twice
    task automatic run_event(input int i);
        logic [31:0] e, st;
        logic kill;
        kill = (i == 2 || i == 3);
        e = (mb[i] >= 0 && m[mb[i]]) ? 32'h0 : 32'h1 << fb[i];
        if (kill && !m[13]) e = e | 32'h8000;
        st = (sb[i] >= 0 ? 32'h1 << sb[i] : 32'h0) | (kill ? 0 : 32'h800);
        wr(CT, 32'h180 | {30'h0, pol, 1'b0});
        sense[src[i]] <= 1'b1;
        tick(6);
        chk_reg(FL, e);
        chk_reg(ST, st);
        chk_pin(8'h70, {1'b0, ~kill ^ pol, {2{~kill}}, 4'h0});
        host.clear(32'h7ffff, q);
        chk_reg(FL, i < 4 ? e & ~32'h8000 : 0);
        sense[src[i]] <= 1'b0;
        tick(6);
        host.clear(32'h7ffff, q);
        chk_reg(FL, 32'h0);
        chk_pin(8'h80, 8'h80);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(16);
        nrst <= 1'b1;
        tick(8);
        chk_pin(8'h80, 8'h00);
        chk_reg(FL, 32'h40000);
        host.clear(32'h40000, q);
        chk_pin(8'h80, 8'h80);
        $display("test boot finished");
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            m = $random(seed);
            m = p ? m & 32'hffff : m & 32'h1feb;
            wr(MK, m);
            chk_reg(MK, m);
            for (int i = 0; i < 6; i++) run_event(i);
        end
        $display("test events finished");
        wr(MK, 32'h0);
        sense[17] <= 1'b1;
        tick(900);
        chk_reg(FL, 32'h0);
        tick(200);
        chk_reg(FL, 32'h1);
        host.clear(32'h1, q);
        chk_reg(FL, 32'h1);
        sense[17] <= 1'b0;
        tick(4);
        host.clear(32'h1, q);
        chk_reg(FL, 32'h0);
        $display("test overcurrent finished");
        wr(MK, 32'h1040);
        sense[7:4] <= 4'hf;
        tick(6);
        chk_reg(FL, 32'h6800);
        chk_reg(ST, 32'hf80);
        host.clear(32'h7ffff, q);
        sense[7:4] <= 4'h0;
        tick(6);
        chk_reg(FL, 32'h3800);
        host.clear(32'h7ffff, q);
        wr(MK, 32'h0);
        $display("test goodness finished");
        sense[14:11] <= 4'hd;
        wr(CT, 32'h68);
        chk_pin(8'h0f, 8'h0d);
        tick(40);
        chk_pin(8'h0f, 8'h00);
        chk_reg(FL, 32'h80d0);
        sense[14:11] <= 4'h0;
        host.clear(32'h7ffff, q);
        $display("test short finished");
        sense[0] <= 1'b1;
        tick(4);
        wr(MK, 32'h10);
        wr(CT, 32'h1);
        tick(8);
        chk_reg(MK, 32'h10000);
        chk_reg(FL, 32'h0);
        sense[0] <= 1'b0;
        wr(CT, 32'h180);
        sense[1] <= 1'b1;
        tick(6);
        chk_pin(8'hbf, 8'h80);
        sense[1] <= 1'b0;
        tick(10);
        chk_reg(MK, 32'h0);
        chk_reg(FL, 32'h40000);
        host.clear(32'h40000, q);
        wr(CT, 32'h4);
        tick(4);
        chk_reg(FL, 32'h10000);
        $display("test resets finished");
        tally_and_finish();
    end
endmodule
